// ==== wdac_pkg.sv ====
// package for the waveform converter control block
// assumes a plain address/strobe register port with 4-bit register indices
package wdac_pkg;
	// ==========================================================
	// register indices (word offsets on the plain port)
	localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
	localparam logic [3:0]  ADDR_SOURCE    = 4'h1;
	localparam logic [3:0]  ADDR_CODE      = 4'h2;
	localparam logic [3:0]  ADDR_KEY_FIRST = 4'h3;
	localparam logic [3:0]  ADDR_KEY_SECOND= 4'h4;
	localparam logic [3:0]  ADDR_REFERENCE = 4'h5;
	localparam logic [3:0]  ADDR_STATUS    = 4'h6;
	// ==========================================================
	// control field positions
	localparam int SHUF_MODE_HI = 10;
	localparam int SHUF_MODE_LO = 9;
	localparam int MSB_SHUF_BIT = 8;
	localparam int LSB_SHUF_BIT = 7;
	localparam int PWR_RED_BIT  = 6;
	localparam int LINE_EN_BIT  = 5;
	localparam int DIFF_BIT     = 4;
	localparam int RSVD_BIT     = 3;
	localparam int OP_MODE_HI   = 2;
	localparam int OP_MODE_LO   = 1;
	localparam int RATE_BIT     = 0;
	// ==========================================================
	// reset values and codes
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_MASK  = 16'h07F7;
	localparam logic [9:0]  CODE_RESET    = 10'h000;
	localparam logic [7:0]  KEY_FIRST_VAL = 8'h07;
	localparam logic [7:0]  KEY_SECOND_VAL= 8'hB9;
	localparam logic [7:0]  REF_ENABLE_VAL= 8'h01;
	localparam logic [1:0]  OP_POWERDOWN  = 2'h0;
	localparam logic [1:0]  OP_RUN        = 2'h3;
	localparam logic [1:0]  SHUF_STEP     = 2'h0;
	localparam logic [1:0]  SHUF_COUNTER  = 2'h1;
	localparam logic [1:0]  SHUF_DATA     = 2'h2;
	typedef enum logic [1:0] {KEY_IDLE, KEY_OPEN, KEY_ARMED} key_state_t;
endpackage : wdac_pkg

// ==== waveform_dac_control.sv ====
// control logic for a 10-bit waveform converter with line driver
// assumes the timer 1 pin is asynchronous and the sine samples share SYS_CLK
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps

// What this block does
// RULE1: shuffle mode picks step, counter, or data rotation
// RULE2: msb enable gates shuffling of upper elements
// RULE3: lsb enable gates shuffling of lower elements
// RULE4: power reduction bit drives low-power output
// RULE5: line enable drives output, else high impedance
// RULE6: differential bit selects differential or single-ended
// RULE7: software writes zero to reserved bit three
// RULE8: mode 00 powers down, 11 runs
// RULE9: update on timer1 falling edge or bus clock
// RULE10: rate bit ignored when sine source used
// RULE11: software enables reference with value 01 first
// RULE12: source bit one direct code, zero sine
// RULE13: key 07, target write, key B9 commit
// RULE14: code register holds 10-bit signed value
// RULE15: staged code applied only on update edge
module waveform_dac_control #(
	parameter int ELEM_W = 4
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	// register port
	input  wire logic [3:0]  ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	// timer and synthesiser inputs
	input  wire logic        TIMER1_PIN,
	input  wire logic [9:0]  SINE_SAMPLE,
	// converter core controls
	output logic [9:0]       CONVERTER_CODE,
	output logic [ELEM_W-1:0] MSB_ROTATION,
	output logic [ELEM_W-1:0] LSB_ROTATION,
	output logic             CONVERTER_ENABLE,
	output logic             POWER_REDUCE,
	output logic             LINE_DRIVE_OE_N,
	output logic             DIFFERENTIAL,
	output logic             REFERENCE_ON
);
	// elaboration check: a pointer may follow the code, so it cannot be wider than the code
	if (ELEM_W < 1 || ELEM_W > 10) begin : g_bad_width
		$error("ELEM_W out of range");
	end

	// ==========================================================
	// register state
	logic [15:0] control_r, control_nxt;
	logic        source_r, source_nxt;
	logic [9:0]  stage_r, stage_nxt;
	logic        stage_src_r, stage_src_nxt;
	logic        stage_code_r, stage_code_nxt;
	logic [7:0]  reference_r, reference_nxt;
	wdac_pkg::key_state_t key_r, key_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	// committed values, declared here because the read mux shows code_r, active_src_r and pending_r
	logic [9:0]  pending_code_r, pending_code_nxt;
	logic        pending_r, pending_nxt;
	logic        pend_src_r, pend_src_nxt;
	logic        pend_src_v_r, pend_src_v_nxt;
	logic [9:0]  code_r, code_nxt;
	logic        active_src_r, active_src_nxt;

	// key sequence: only a write bracketed by the two keys commits
	always_comb begin
		control_nxt    = control_r;
		source_nxt     = source_r;
		stage_nxt      = stage_r;
		stage_src_nxt  = stage_src_r;
		stage_code_nxt = stage_code_r;
		reference_nxt  = reference_r;
		key_nxt        = key_r;
		rdata_nxt      = 16'h0000;
		if (WR) begin
			case (ADDR)
				wdac_pkg::ADDR_CONTROL: begin
					// reserved bit forced low in case software breaks the convention
					control_nxt = WDATA & wdac_pkg::CONTROL_MASK; // RULE7
				end
				wdac_pkg::ADDR_REFERENCE: begin
					reference_nxt = WDATA[7:0]; // RULE11
				end
				wdac_pkg::ADDR_KEY_FIRST: begin
					key_nxt = (WDATA[7:0] == wdac_pkg::KEY_FIRST_VAL) ? wdac_pkg::KEY_OPEN : wdac_pkg::KEY_IDLE; // RULE13
					stage_src_nxt  = 1'b0;
					stage_code_nxt = 1'b0;
				end
				wdac_pkg::ADDR_SOURCE: begin
					if (key_r == wdac_pkg::KEY_OPEN) begin
						source_nxt    = WDATA[0]; // RULE13
						stage_src_nxt = 1'b1;
						key_nxt       = wdac_pkg::KEY_ARMED;
					end else begin
						key_nxt = wdac_pkg::KEY_IDLE;
					end
				end
				wdac_pkg::ADDR_CODE: begin
					if (key_r == wdac_pkg::KEY_OPEN) begin
						stage_nxt      = WDATA[9:0]; // RULE14
						stage_code_nxt = 1'b1;
						key_nxt        = wdac_pkg::KEY_ARMED;
					end else begin
						key_nxt = wdac_pkg::KEY_IDLE;
					end
				end
				wdac_pkg::ADDR_KEY_SECOND: begin
					// the second key validates the staged write; anything else drops it
					if (key_r == wdac_pkg::KEY_ARMED && WDATA[7:0] == wdac_pkg::KEY_SECOND_VAL) begin
						key_nxt = wdac_pkg::KEY_IDLE; // RULE13
					end else begin
						key_nxt        = wdac_pkg::KEY_IDLE;
						stage_src_nxt  = 1'b0;
						stage_code_nxt = 1'b0;
					end
				end
				default: begin
					key_nxt = key_r;
				end
			endcase
		end
		if (RD) begin
			case (ADDR)
				wdac_pkg::ADDR_CONTROL:   rdata_nxt = control_r;
				wdac_pkg::ADDR_SOURCE:    rdata_nxt = {15'h0000, active_src_r};
				wdac_pkg::ADDR_CODE:      rdata_nxt = {6'h00, code_r};
				wdac_pkg::ADDR_REFERENCE: rdata_nxt = {8'h00, reference_r};
				wdac_pkg::ADDR_STATUS:    rdata_nxt = {12'h000, pending_r, 1'b0, key_r};
				default:                  rdata_nxt = 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// timer 1 synchroniser and falling edge detect
	logic t1_meta_r, t1_sync_r, t1_prev_r;
	logic t1_fall;
	assign t1_fall = t1_prev_r & ~t1_sync_r;

	// ==========================================================
	// committed values, applied on update edges
	logic       commit;
	logic       update_tick;
	assign commit = WR && ADDR == wdac_pkg::ADDR_KEY_SECOND && key_r == wdac_pkg::KEY_ARMED
		&& WDATA[7:0] == wdac_pkg::KEY_SECOND_VAL;
	// rate bit picks timer 1 or every bus clock; sine source ignores it
	assign update_tick = control_r[wdac_pkg::RATE_BIT] ? t1_fall : 1'b1; // RULE9

	always_comb begin
		pending_code_nxt = pending_code_r;
		pending_nxt      = pending_r;
		pend_src_nxt     = pend_src_r;
		pend_src_v_nxt   = pend_src_v_r;
		code_nxt         = code_r;
		active_src_nxt   = active_src_r;
		// a fresh commit in the tick cycle wins: staged again for the next tick
		if (update_tick) begin
			if (pending_r) code_nxt = pending_code_r; // RULE15
			if (pend_src_v_r) active_src_nxt = pend_src_r;
			pending_nxt    = 1'b0;
			pend_src_v_nxt = 1'b0;
		end
		if (commit && stage_code_r) begin
			pending_code_nxt = stage_r;
			pending_nxt      = 1'b1;
		end
		if (commit && stage_src_r) begin
			pend_src_nxt   = source_r;
			pend_src_v_nxt = 1'b1;
		end
	end

	// ==========================================================
	// shuffle pointers
	logic [ELEM_W-1:0] msb_rot_r, msb_rot_nxt, lsb_rot_r, lsb_rot_nxt;
	logic [ELEM_W-1:0] free_cnt_r, free_cnt_nxt;
	logic [9:0]        out_code_r, out_code_nxt;
	logic              running;
	assign running = control_r[wdac_pkg::OP_MODE_HI:wdac_pkg::OP_MODE_LO] == wdac_pkg::OP_RUN; // RULE8

	always_comb begin
		logic [ELEM_W-1:0] step;
		step         = '0;
		free_cnt_nxt = free_cnt_r + 1'b1;
		msb_rot_nxt  = msb_rot_r;
		lsb_rot_nxt  = lsb_rot_r;
		out_code_nxt = out_code_r;
		case (control_r[wdac_pkg::SHUF_MODE_HI:wdac_pkg::SHUF_MODE_LO]) // RULE1
			wdac_pkg::SHUF_STEP:    step = msb_rot_r + 1'b1;
			wdac_pkg::SHUF_COUNTER: step = free_cnt_r;
			wdac_pkg::SHUF_DATA:    step = out_code_r[ELEM_W-1:0];
			default:                step = msb_rot_r; // reserved: msb holds, lsb takes the msb pointer
		endcase
		if (running) begin
			// sine samples stream every clock regardless of the rate bit
			if (!active_src_r) begin
				out_code_nxt = SINE_SAMPLE; // RULE10 RULE12
			end else begin
				out_code_nxt = code_r; // RULE12
			end
			// pointers advance on update edges, or every clock with the sine source; a cleared enable parks them at once
			if (!control_r[wdac_pkg::MSB_SHUF_BIT]) begin
				msb_rot_nxt = '0; // RULE2
			end else if (!active_src_r || update_tick) begin
				msb_rot_nxt = step; // RULE2
			end
			if (!control_r[wdac_pkg::LSB_SHUF_BIT]) begin
				lsb_rot_nxt = '0; // RULE3
			end else if (!active_src_r || update_tick) begin
				lsb_rot_nxt = step; // RULE3
			end
		end else begin
			out_code_nxt = wdac_pkg::CODE_RESET;
			msb_rot_nxt  = '0;
			lsb_rot_nxt  = '0;
		end
	end

	// ==========================================================
	// bus-facing registers; reset is synchronous and loads constants only
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			control_r    <= wdac_pkg::CONTROL_RESET;
			source_r     <= 1'b0;
			stage_r      <= wdac_pkg::CODE_RESET;
			stage_src_r  <= 1'b0;
			stage_code_r <= 1'b0;
			reference_r  <= 8'h00;
			key_r        <= wdac_pkg::KEY_IDLE;
			rdata_r      <= 16'h0000;
		end else begin
			control_r    <= control_nxt;
			source_r     <= source_nxt;
			stage_r      <= stage_nxt;
			stage_src_r  <= stage_src_nxt;
			stage_code_r <= stage_code_nxt;
			reference_r  <= reference_nxt;
			key_r        <= key_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	// ==========================================================
	// timer 1 synchroniser registers
	// the edge detect reads the second and third stages; a low reset value can fake a rise, never a fall
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			t1_meta_r <= 1'b0;
			t1_sync_r <= 1'b0;
			t1_prev_r <= 1'b0;
		end else begin
			t1_meta_r <= TIMER1_PIN;
			t1_sync_r <= t1_meta_r;
			t1_prev_r <= t1_sync_r;
		end
	end

	// ==========================================================
	// commit and applied-value registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pending_code_r <= wdac_pkg::CODE_RESET;
			pending_r      <= 1'b0;
			pend_src_r     <= 1'b0;
			pend_src_v_r   <= 1'b0;
			code_r         <= wdac_pkg::CODE_RESET;
			active_src_r   <= 1'b0;
		end else begin
			pending_code_r <= pending_code_nxt;
			pending_r      <= pending_nxt;
			pend_src_r     <= pend_src_nxt;
			pend_src_v_r   <= pend_src_v_nxt;
			code_r         <= code_nxt;
			active_src_r   <= active_src_nxt;
		end
	end

	// ==========================================================
	// shuffle pointer and output code registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			msb_rot_r  <= '0;
			lsb_rot_r  <= '0;
			free_cnt_r <= '0;
			out_code_r <= wdac_pkg::CODE_RESET;
		end else begin
			msb_rot_r  <= msb_rot_nxt;
			lsb_rot_r  <= lsb_rot_nxt;
			free_cnt_r <= free_cnt_nxt;
			out_code_r <= out_code_nxt;
		end
	end

	// ==========================================================
	// output decode registers
	// decoded from the next values so they switch on the same edge as the raw control bits
	logic enable_r, enable_nxt;
	logic line_oe_n_r, line_oe_n_nxt;
	logic ref_on_r, ref_on_nxt;
	assign enable_nxt    = control_nxt[wdac_pkg::OP_MODE_HI] & control_nxt[wdac_pkg::OP_MODE_LO]; // RULE8
	assign line_oe_n_nxt = ~control_nxt[wdac_pkg::LINE_EN_BIT]; // RULE5
	assign ref_on_nxt    = reference_nxt == wdac_pkg::REF_ENABLE_VAL; // RULE11

	// the line driver comes out of reset released (high impedance)
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			enable_r    <= 1'b0;
			line_oe_n_r <= 1'b1;
			ref_on_r    <= 1'b0;
		end else begin
			enable_r    <= enable_nxt;
			line_oe_n_r <= line_oe_n_nxt;
			ref_on_r    <= ref_on_nxt;
		end
	end

	// ==========================================================
	// outputs straight from flip-flops
	assign RDATA            = rdata_r;
	assign CONVERTER_CODE   = out_code_r;
	assign MSB_ROTATION     = msb_rot_r;
	assign LSB_ROTATION     = lsb_rot_r;
	assign CONVERTER_ENABLE = enable_r; // RULE8
	assign POWER_REDUCE     = control_r[wdac_pkg::PWR_RED_BIT]; // RULE4
	assign LINE_DRIVE_OE_N  = line_oe_n_r; // RULE5
	assign DIFFERENTIAL     = control_r[wdac_pkg::DIFF_BIT]; // RULE6
	assign REFERENCE_ON     = ref_on_r; // RULE11
endmodule : waveform_dac_control

// ==== waveform_dac_control_properties.sv ====
// port checker for the waveform converter control block
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
module waveform_dac_control_properties #(
	parameter int ELEM_W = 4
) (
	// clock and reset
	input wire logic              SYS_CLK,
	input wire logic              RST_N,
	// register port
	input wire logic [3:0]        ADDR,
	input wire logic [15:0]       WDATA,
	input wire logic              WR,
	input wire logic              RD,
	input wire logic [15:0]       RDATA,
	// converter controls
	input wire logic [9:0]        CONVERTER_CODE,
	input wire logic [ELEM_W-1:0] MSB_ROTATION,
	input wire logic [ELEM_W-1:0] LSB_ROTATION,
	input wire logic              CONVERTER_ENABLE,
	input wire logic              POWER_REDUCE,
	input wire logic              LINE_DRIVE_OE_N,
	input wire logic              DIFFERENTIAL,
	input wire logic              REFERENCE_ON
);
	// ==========================================================
	// shared decode and sequences
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	wire ctl_wr = WR && ADDR == wdac_pkg::ADDR_CONTROL;
	// pointers are registered from control, so allow two quiet cycles
	sequence msb_off_s; ctl_wr && !WDATA[8] ##1 !ctl_wr [*2]; endsequence
	sequence lsb_off_s; ctl_wr && !WDATA[7] ##1 !ctl_wr [*2]; endsequence
	// ==========================================================
	// control outputs
	pwr_follow_a: assert property (ctl_wr |=> POWER_REDUCE == $past(WDATA[6]))
		else $error("power reduce does not follow control");
	line_oe_a: assert property (ctl_wr |=> LINE_DRIVE_OE_N == !$past(WDATA[5]))
		else $error("line enable does not follow control");
	diff_out_a: assert property (ctl_wr |=> DIFFERENTIAL == $past(WDATA[4]))
		else $error("differential does not follow control");
	run_mode_a: assert property (ctl_wr |=> CONVERTER_ENABLE == ($past(WDATA[2:1]) == 2'h3))
		else $error("enable does not match mode");
	code_off_a: assert property (!CONVERTER_ENABLE [*2] |-> CONVERTER_CODE == 10'h000)
		else $error("code not zero while stopped");
	msb_off_a: assert property (msb_off_s |-> MSB_ROTATION == '0)
		else $error("msb pointer moves while disabled");
	lsb_off_a: assert property (lsb_off_s |-> LSB_ROTATION == '0)
		else $error("lsb pointer moves while disabled");
	ref_on_a: assert property (WR && ADDR == wdac_pkg::ADDR_REFERENCE |=>
		REFERENCE_ON == ($past(WDATA[7:0]) == wdac_pkg::REF_ENABLE_VAL))
		else $error("reference flag wrong");
	rdata_idle_a: assert property (!RD |=> RDATA == 16'h0000)
		else $error("read data outside read slot");
endmodule : waveform_dac_control_properties

bind waveform_dac_control waveform_dac_control_properties #(.ELEM_W(ELEM_W)) u_props (.SYS_CLK(SYS_CLK),
	.RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CONVERTER_CODE(CONVERTER_CODE),
	.MSB_ROTATION(MSB_ROTATION), .LSB_ROTATION(LSB_ROTATION), .CONVERTER_ENABLE(CONVERTER_ENABLE),
	.POWER_REDUCE(POWER_REDUCE), .LINE_DRIVE_OE_N(LINE_DRIVE_OE_N), .DIFFERENTIAL(DIFFERENTIAL),
	.REFERENCE_ON(REFERENCE_ON));

// ==== tb_waveform_dac_control.sv ====
// self-checking bench for the waveform converter control block
// assumes package, design and checker are compiled before it
`timescale 1ns/10ps
module tb_waveform_dac_control;
	// ==========================================================
	// nets
	logic        SYS_CLK, RST_N, WR, RD, TIMER1_PIN;
	logic [3:0]  ADDR, MSB_ROTATION, LSB_ROTATION;
	logic [15:0] WDATA, RDATA, rv;
	logic [9:0]  SINE_SAMPLE, CONVERTER_CODE;
	logic        CONVERTER_ENABLE, POWER_REDUCE, LINE_DRIVE_OE_N, DIFFERENTIAL, REFERENCE_ON;
	int          error_cnt = 0;
	int          cmp_count = 0;
	waveform_dac_control dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .TIMER1_PIN(TIMER1_PIN), .SINE_SAMPLE(SINE_SAMPLE), .CONVERTER_CODE(CONVERTER_CODE),
		.MSB_ROTATION(MSB_ROTATION), .LSB_ROTATION(LSB_ROTATION), .CONVERTER_ENABLE(CONVERTER_ENABLE),
		.POWER_REDUCE(POWER_REDUCE), .LINE_DRIVE_OE_N(LINE_DRIVE_OE_N), .DIFFERENTIAL(DIFFERENTIAL),
		.REFERENCE_ON(REFERENCE_ON));
	// 100 MHz clock
	initial begin
		SYS_CLK = 0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	// ==========================================================
	// bus helpers; wr leaves the strobe up so writes can run back to back
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		WR <= 1;
		ADDR <= a;
		WDATA <= d;
		@(posedge SYS_CLK);
	endtask : wr
	task automatic idle(input int n);
		WR <= 0;
		RD <= 0;
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : idle
	task automatic rd(input logic [3:0] a);
		WR <= 0;
		RD <= 1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD <= 0;
		#1 rv = RDATA;
	endtask : rd
	// protected write: first key, target, second key
	task automatic kw(input logic [3:0] a, input logic [15:0] d);
		wr(wdac_pkg::ADDR_KEY_FIRST, 16'h0007);
		wr(a, d);
		wr(wdac_pkg::ADDR_KEY_SECOND, 16'h00B9);
		idle(1);
	endtask : kw
	// bounded wait; a miss ends the run
	task automatic wait_code(input logic [9:0] e);
		for (int i = 0; i < 40 && CONVERTER_CODE !== e; i++) begin
			@(posedge SYS_CLK);
			#1;
		end
		chk("converter code", 16'(e), 16'(CONVERTER_CODE));
		if (CONVERTER_CODE !== e) final_report();
	endtask : wait_code
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// ==========================================================
	// scenarios
	task automatic t_control();
		logic [15:0] w;
		logic [1:0]  m;
		logic        seen;
		chk("oe_n at reset", 16'h0001, 16'(LINE_DRIVE_OE_N));
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			w = {5'h1F, m, {5{m[0]}}, 1'b0, m, m[0]};
			wr(wdac_pkg::ADDR_CONTROL, w);
			rd(wdac_pkg::ADDR_CONTROL);
			chk("control readback", w & wdac_pkg::CONTROL_MASK, rv);
			chk("power reduce", 16'(m[0]), 16'(POWER_REDUCE));
			chk("line oe_n", 16'(!m[0]), 16'(LINE_DRIVE_OE_N));
			chk("differential", 16'(m[0]), 16'(DIFFERENTIAL));
			chk("enable", 16'(m == 2'h3), 16'(CONVERTER_ENABLE));
		end
		// counter shuffle with both enables while running: pointers must move
		wr(wdac_pkg::ADDR_CONTROL, 16'h0386);
		idle(1);
		seen = 0;
		repeat (20) begin
			seen |= (MSB_ROTATION !== 4'h0) && (LSB_ROTATION !== 4'h0);
			@(posedge SYS_CLK);
			#1;
		end
		chk("pointers move", 16'h0001, 16'(seen));
		// step shuffle, msb only: one increment per update, lsb parked
		wr(wdac_pkg::ADDR_CONTROL, 16'h0106);
		idle(2);
		rv = {12'h000, MSB_ROTATION};
		@(posedge SYS_CLK);
		#1;
		chk("step advance", (rv + 16'h0001) & 16'h000F, 16'(MSB_ROTATION));
		chk("lsb parked", 16'h0000, 16'(LSB_ROTATION));
		// data shuffle follows the low bits of the sine sample 0x0AA
		wr(wdac_pkg::ADDR_CONTROL, 16'h0506);
		idle(3);
		chk("data shuffle", 16'h000A, 16'(MSB_ROTATION));
		$display("test control finished");
	endtask : t_control
	task automatic t_ref();
		wr(wdac_pkg::ADDR_REFERENCE, 16'h0001);
		idle(1);
		chk("reference on", 16'h0001, 16'(REFERENCE_ON));
		wr(wdac_pkg::ADDR_REFERENCE, 16'h0002);
		idle(1);
		chk("reference off", 16'h0000, 16'(REFERENCE_ON));
		// leave the reference on before the converter is used
		wr(wdac_pkg::ADDR_REFERENCE, 16'h0001);
		$display("test reference finished");
	endtask : t_ref
	task automatic t_key();
		wr(wdac_pkg::ADDR_CONTROL, 16'h0006);
		wr(wdac_pkg::ADDR_CODE, 16'h01FF);
		rd(wdac_pkg::ADDR_CODE);
		chk("unkeyed code", 16'h0000, rv);
		kw(wdac_pkg::ADDR_SOURCE, 16'h0001);
		kw(wdac_pkg::ADDR_CODE, 16'h01FF);
		wait_code(10'h1FF);
		kw(wdac_pkg::ADDR_CODE, 16'h0200);
		wait_code(10'h200);
		$display("test key finished");
	endtask : t_key
	task automatic t_rate();
		wr(wdac_pkg::ADDR_CONTROL, 16'h0007);
		kw(wdac_pkg::ADDR_CODE, 16'h0123);
		idle(8);
		chk("held until tick", 16'h0200, 16'(CONVERTER_CODE));
		TIMER1_PIN <= 0;
		wait_code(10'h123);
		TIMER1_PIN <= 1;
		$display("test rate finished");
	endtask : t_rate
	task automatic t_sine();
		wr(wdac_pkg::ADDR_CONTROL, 16'h0006);
		kw(wdac_pkg::ADDR_SOURCE, 16'h0000);
		wait_code(10'h0AA);
		wr(wdac_pkg::ADDR_CONTROL, 16'h0007);
		idle(1);
		SINE_SAMPLE <= 10'h155;
		wait_code(10'h155);
		wr(wdac_pkg::ADDR_CONTROL, 16'h0000);
		idle(1);
		wait_code(10'h000);
		$display("test sine finished");
	endtask : t_sine
	// ==========================================================
	// main sequence
	initial begin
		RST_N = 0;
		WR = 0;
		RD = 0;
		ADDR = 0;
		WDATA = 0;
		TIMER1_PIN = 1;
		SINE_SAMPLE = 10'h0AA;
		repeat (20) @(posedge SYS_CLK);
		RST_N <= 1;
		@(posedge SYS_CLK);
		#1;
		t_control();
		t_ref();
		t_key();
		t_rate();
		t_sine();
		final_report();
	end
endmodule : tb_waveform_dac_control
